// [core/sram_port_consts.svh]
// constants for the pipelined burst sram host port
// assumes inclusion by bare name from every design file but the package
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

// one byte-write lane carries eight data bits plus parity
`define LANE_W          9
// 512k x 36 organisation (default build)
`define X36_ADDR_W      19
`define X36_DATA_W      36
`define X36_LANES       4
// 1m x 18 organisation
`define X18_ADDR_W      20
`define X18_DATA_W      18
`define X18_LANES       2
// burst counter spans the two low address bits
`define BURST_W         2
// accepted edges from address capture to read data / write data
`define DATA_LAT        2
// burst-order strap: low selects linear, high or floating interleaved
`define STRAP_LINEAR    1'b0
// zero-wait grades in mhz and the clock this build runs at
`define GRADE_TOP_MHZ   250
`define GRADE_MID_MHZ   200
`define GRADE_LOW_MHZ   167
`define SYS_CLK_MHZ     40

`endif

// [core/sram_port_pkg.sv]
// types shared by the sram port files
// assumes nothing beyond a systemverilog compiler
package sram_port_pkg;

    // gray-coded along nop -> read -> write
    typedef enum logic [1:0] {
        OP_NOP   = 2'h0,
        OP_READ  = 2'h1,
        OP_WRITE = 2'h3
    } op_t;

    // synchronous control pins sampled with the address
    typedef struct packed {
        logic write_en_n;
        logic adv_ld;
        logic chip_sel1_n;
        logic chip_sel2;
        logic chip_sel3_n;
    } ctl_pins_t;

endpackage

// [core/burst_addr_gen.sv]
// burst order for the two low address bits
// assumes the caller holds base and count stable between accepted edges
`timescale 1ns/1ps
`include "sram_port_consts.svh"

module burst_addr_gen (
    // burst state
    input  wire logic [`BURST_W-1:0] base_in,
    input  wire logic [`BURST_W-1:0] count_in,
    // order select: high means interleaved
    input  wire logic                interleave_in,
    // resulting low address bits
    output logic      [`BURST_W-1:0] low_addr_out
);

    // linear wraps by adding, interleaved by flipping bits
    always_comb begin
        if (interleave_in) begin
            low_addr_out = base_in ^ count_in;
        end else begin
            low_addr_out = base_in + count_in;
        end
    end

endmodule

// [core/sram_array.sv]
// storage array with lane-gated writes and a registered read port
// assumes one clock; enable low freezes both ports
`timescale 1ns/1ps
`include "sram_port_consts.svh"

module sram_array #(
    parameter int ADDR_W = `X36_ADDR_W,
    parameter int LANES  = `X36_LANES
) (
    // clock, reset and accepted-edge enable
    input  wire logic                      sys_clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      en_in,
    // read port
    input  wire logic                      rd_en_in,
    input  wire logic [ADDR_W-1:0]         rd_addr_in,
    output logic      [LANES*`LANE_W-1:0]  rd_data_out,
    // write port
    input  wire logic                      wr_en_in,
    input  wire logic [ADDR_W-1:0]         wr_addr_in,
    input  wire logic [LANES-1:0]          wr_lanes_in,
    input  wire logic [LANES*`LANE_W-1:0]  wr_data_in
);

    logic same_addr;

    assign same_addr = wr_en_in && (wr_addr_in == rd_addr_in);

    genvar l;
    generate
        for (l = 0; l < LANES; l++) begin : g_lane
            // one array per lane, so each lane has a single writer
            logic [`LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
            // lane is written only when its select is active
            always_ff @(posedge sys_clk_in) begin
                if (en_in && wr_en_in && wr_lanes_in[l]) begin
                    mem[wr_addr_in] <= wr_data_in[l*`LANE_W +: `LANE_W];
                end
            end
            // write-first, so a same-edge write is never missed
            always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    rd_data_out[l*`LANE_W +: `LANE_W] <= '0;
                end else if (en_in && rd_en_in) begin
                    if (same_addr && wr_lanes_in[l]) begin
                        rd_data_out[l*`LANE_W +: `LANE_W] <=
                            wr_data_in[l*`LANE_W +: `LANE_W];
                    end else begin
                        rd_data_out[l*`LANE_W +: `LANE_W] <=
                            mem[rd_addr_in];
                    end
                end
            end
        end
    endgenerate

endmodule

// [core/sram_burst_port.sv]
// synchronous burst sram port: input regs, array, output regs
// assumes the controller runs on sys_clk_in and drives pins on its edges
//
// Behaviour
// [R1] every synchronous input is taken into registers on the rising edge.
// [R2] read data leaves through a register updated on the rising edge.
// [R3] a high clock gate makes the edge count for nothing; all state holds. The sleep and strap sync flops and interleave still update on gated edges.
// [R4] reads and writes mix freely on consecutive cycles without waits.
// [R5] the data outputs go high impedance in every write data phase.
// [R6] the port is selected only with sel1 low, sel2 high and sel3 low.
// [R7] a high asynchronous output enable forces the outputs off at once.
// [R8] accepted writes finish internally with no extra pulse from outside.
// [R9] output driver turn-on and turn-off are timed internally.
// [R10] bursts run linear with the strap low and interleaved otherwise.
// [R11] a sleep input idles the port, and a stopped clock is tolerated.
// [R12] the array is 512k x 36 or 1m x 18 with widths to match.
// [R13] zero-wait operation holds up to the 250, 200 and 167 mhz grades.
// [R14] each lane select gates one nine-bit lane of a write.
// [R15] read and write data sit two accepted edges after the address.
`timescale 1ns/1ps
`include "sram_port_consts.svh"

module sram_burst_port #(
    // [R12] organisation
    parameter int ADDR_W = `X36_ADDR_W,
    parameter int LANES  = `X36_LANES
) (
    // clock and reset
    input  wire logic                          sys_clk_in,
    input  wire logic                          rst_n_in,
    // synchronous pins from the controller
    input  wire logic                          clock_gate_n_in,
    input  wire logic [ADDR_W-1:0]             addr_in,
    input  wire sram_port_pkg::ctl_pins_t      ctl_in,
    input  wire logic [LANES-1:0]              lane_write_sel_n_in,
    input  wire logic [LANES*`LANE_W-1:0]      dq_in,
    // asynchronous pins
    input  wire logic                          out_en_n_in,
    input  wire logic                          sleep_req_in,
    input  wire logic                          burst_mode_in,
    // data pins
    output logic      [LANES*`LANE_W-1:0]      dq_out,
    output logic                               dq_oe_out
);

    localparam int DW = LANES * `LANE_W;

    typedef struct packed {
        sram_port_pkg::op_t  a_op;
        logic [ADDR_W-1:0]   a_addr;
        logic [`BURST_W-1:0] a_cnt;
        logic [LANES-1:0]    a_lanes;
        sram_port_pkg::op_t  b_op;
        logic [ADDR_W-1:0]   b_addr;
        logic [LANES-1:0]    b_lanes;
        sram_port_pkg::op_t  c_op;
        logic [ADDR_W-1:0]   c_addr;
        logic [LANES-1:0]    c_lanes;
        logic [DW-1:0]       wdat;
        logic [DW-1:0]       dout;
        logic                oe;
        logic                sleep_s1;
        logic                sleep_s2;
        logic                mode_s1;
        logic                mode_s2;
        logic                interleave;
    } state_t;

    state_t              st_r;
    state_t              st_nxt;
    logic                en;
    logic                selected;
    logic [`BURST_W-1:0] low_addr;
    logic [ADDR_W-1:0]   eff_addr;
    logic [DW-1:0]       rd_data;
    logic [DW-1:0]       fwd_data;
    logic                fwd_hit;

    ////////////////////////////////////////////////////////////////////
    // [R3] clock gate qualifies every edge
    assign en = !clock_gate_n_in;

    // [R6] all three selects, and nothing while asleep
    assign selected = !ctl_in.chip_sel1_n && ctl_in.chip_sel2 &&
                      !ctl_in.chip_sel3_n && !st_r.sleep_s2;

    ////////////////////////////////////////////////////////////////////
    // [R10] burst order on low bits
    burst_addr_gen u_burst (
        .base_in       (st_r.a_addr[`BURST_W-1:0]),
        .count_in      (st_r.a_cnt),
        .interleave_in (st_r.interleave),
        .low_addr_out  (low_addr)
    );

    assign eff_addr = {st_r.a_addr[ADDR_W-1:`BURST_W], low_addr};

    ////////////////////////////////////////////////////////////////////
    // [R8] self-timed write from the data register
    sram_array #(
        .ADDR_W (ADDR_W),
        .LANES  (LANES)
    ) u_array (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .en_in       (en),
        .rd_en_in    (st_r.a_op == sram_port_pkg::OP_READ),
        .rd_addr_in  (eff_addr),
        .rd_data_out (rd_data),
        .wr_en_in    (st_r.c_op == sram_port_pkg::OP_WRITE),
        .wr_addr_in  (st_r.c_addr),
        .wr_lanes_in (st_r.c_lanes),
        .wr_data_in  (st_r.wdat)
    );

    ////////////////////////////////////////////////////////////////////
    // [R4] forward the write that lands on the read's output edge
    assign fwd_hit = (st_r.c_op == sram_port_pkg::OP_WRITE) &&
                     (st_r.c_addr == st_r.b_addr);

    genvar l;
    generate
        for (l = 0; l < LANES; l++) begin : g_fwd
            // [R14] only written lanes override
            assign fwd_data[l*`LANE_W +: `LANE_W] =
                (fwd_hit && st_r.c_lanes[l]) ?
                st_r.wdat[l*`LANE_W +: `LANE_W] :
                rd_data[l*`LANE_W +: `LANE_W];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        // [R11] sleep is asynchronous, so two flops first
        st_nxt.sleep_s1 = sleep_req_in;
        st_nxt.sleep_s2 = st_r.sleep_s1;
        st_nxt.mode_s1  = burst_mode_in;
        st_nxt.mode_s2  = st_r.mode_s1;
        // [R10] strap follows its sync chain; a one-shot capture
        // right after reset would only see the cleared flops
        st_nxt.interleave = (st_r.mode_s2 != `STRAP_LINEAR);
        if (en) begin
            // [R1] address and controls into stage a
            st_nxt.a_lanes = ~lane_write_sel_n_in;
            if (ctl_in.adv_ld) begin
                // [R10] advance keeps the op, steps the count
                if (st_r.a_op != sram_port_pkg::OP_NOP) begin
                    st_nxt.a_cnt = st_r.a_cnt + 2'h1;
                end
            end else begin
                st_nxt.a_addr = addr_in;
                st_nxt.a_cnt  = '0;
                if (!selected) begin
                    st_nxt.a_op = sram_port_pkg::OP_NOP;
                end else if (ctl_in.write_en_n) begin
                    st_nxt.a_op = sram_port_pkg::OP_READ;
                end else begin
                    st_nxt.a_op = sram_port_pkg::OP_WRITE;
                end
            end
            // [R11] a burst does not run on into sleep
            if (st_r.sleep_s2) begin
                st_nxt.a_op = sram_port_pkg::OP_NOP;
            end
            // [R13] no wait states
            // [R15] two stages behind the address
            st_nxt.b_op    = st_r.a_op;
            st_nxt.b_addr  = eff_addr;
            st_nxt.b_lanes = st_r.a_lanes;
            st_nxt.c_op    = st_r.b_op;
            st_nxt.c_addr  = st_r.b_addr;
            st_nxt.c_lanes = st_r.b_lanes;
            // [R1] write data taken in its data phase
            if (st_r.b_op == sram_port_pkg::OP_WRITE) begin
                st_nxt.wdat = dq_in;
            end
            // [R2] read data through the output register
            if (st_r.b_op == sram_port_pkg::OP_READ) begin
                st_nxt.dout = fwd_data;
            end
            // [R9] drivers on for read data only
            // [R5] hence off in every write data phase
            st_nxt.oe = (st_r.b_op == sram_port_pkg::OP_READ);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign dq_out = st_r.dout;
    // [R7] asynchronous enable gates the drivers without the clock
    assign dq_oe_out = st_r.oe && !out_en_n_in;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_capture;
        en && !ctl_in.adv_ld |=> st_r.a_addr == $past(addr_in);
    endproperty
    a_capture: assert property (p_capture) // [R1]
        else $error("address not captured on accepted edge");

    property p_wdat;
        en && st_r.b_op == sram_port_pkg::OP_WRITE |=>
        st_r.wdat == $past(dq_in);
    endproperty
    a_wdat: assert property (p_wdat) // [R1]
        else $error("write data not taken in its data phase");

    property p_dout_hold;
        !(en && st_r.b_op == sram_port_pkg::OP_READ) |=> $stable(st_r.dout);
    endproperty
    a_dout_hold: assert property (p_dout_hold) // [R2]
        else $error("read data register moved outside a read data phase");

    property p_out_reg;
        $changed(st_r.dout) |-> $past(en);
    endproperty
    a_out_reg: assert property (p_out_reg) // [R2]
        else $error("read data changed without an accepted edge");

    property p_hold;
        !en |=> $stable(st_r.a_op) && $stable(st_r.b_op) &&
                $stable(st_r.c_op) && $stable(st_r.oe);
    endproperty
    a_hold: assert property (p_hold) // [R3]
        else $error("pipeline moved on a gated edge");

    property p_b2b;
        (en && st_r.a_op == sram_port_pkg::OP_WRITE) ##1
        (en && st_r.a_op == sram_port_pkg::OP_READ) ##1 en |=> st_r.oe;
    endproperty
    a_b2b: assert property (p_b2b) // [R4]
        else $error("read after write did not drive data");

    property p_wr_hiz;
        en && st_r.b_op == sram_port_pkg::OP_WRITE |=> !dq_oe_out;
    endproperty
    a_wr_hiz: assert property (p_wr_hiz) // [R5]
        else $error("outputs driven in write data phase");

    property p_desel;
        en && !ctl_in.adv_ld && !(!ctl_in.chip_sel1_n &&
        ctl_in.chip_sel2 && !ctl_in.chip_sel3_n)
        |=> st_r.a_op == sram_port_pkg::OP_NOP;
    endproperty
    a_desel: assert property (p_desel) // [R6]
        else $error("operation accepted while deselected");

    property p_async_oe;
        out_en_n_in |-> !dq_oe_out;
    endproperty
    a_async_oe: assert property (p_async_oe) // [R7]
        else $error("outputs driven with output enable off");

    property p_burst;
        en && ctl_in.adv_ld && !st_r.sleep_s2 &&
        st_r.a_op != sram_port_pkg::OP_NOP
        |=> st_r.a_cnt == 2'($past(st_r.a_cnt) + 2'h1) &&
            $stable(st_r.a_op);
    endproperty
    a_burst: assert property (p_burst) // [R10]
        else $error("burst counter did not step");

    property p_sleep;
        en && st_r.sleep_s2 |=> st_r.a_op == sram_port_pkg::OP_NOP;
    endproperty
    a_sleep: assert property (p_sleep) // [R11]
        else $error("operation accepted in sleep");

    property p_lane_fwd;
        en && st_r.b_op == sram_port_pkg::OP_READ && fwd_hit &&
        st_r.c_lanes[0]
        |=> st_r.dout[`LANE_W-1:0] == $past(st_r.wdat[`LANE_W-1:0]);
    endproperty
    a_lane_fwd: assert property (p_lane_fwd) // [R14]
        else $error("written lane not seen by following read");

    property p_rd_lat;
        (en && st_r.a_op == sram_port_pkg::OP_READ) ##1 en
        |=> st_r.oe && $past(st_r.b_op) == sram_port_pkg::OP_READ;
    endproperty
    a_rd_lat: assert property (p_rd_lat) // [R15]
        else $error("read data not two accepted edges after address");

    c_read: cover property (en && st_r.b_op == sram_port_pkg::OP_READ);
    c_wr_rd: cover property (
        (en && st_r.a_op == sram_port_pkg::OP_WRITE) ##1
        (en && st_r.a_op == sram_port_pkg::OP_READ));
    c_burst: cover property (en && ctl_in.adv_ld &&
                             st_r.a_cnt == 2'h3);
    c_stall: cover property (!en && st_r.b_op != sram_port_pkg::OP_NOP);

endmodule

// [test/sram_ctrl_model.sv]
// memory controller model driving the burst port pins
// assumes the bench calls put, idle and pins, one address cycle per put and n per idle
`timescale 1ns/1ps
`include "sram_port_consts.svh"

module sram_ctrl_model #(
    parameter int ADDR_W = `X36_ADDR_W,
    parameter int LANES  = `X36_LANES
) (
    // clock
    input  wire logic                     sys_clk_in,
    // pins toward the port
    output logic                          clock_gate_n_out,
    output logic [ADDR_W-1:0]             addr_out,
    output sram_port_pkg::ctl_pins_t      ctl_out,
    output logic [LANES-1:0]              lane_write_sel_n_out,
    output logic [LANES*`LANE_W-1:0]      dq_out,
    output logic                          out_en_n_out,
    output logic                          sleep_req_out,
    output logic                          burst_mode_out,
    // pins from the port
    input  wire logic [LANES*`LANE_W-1:0] dq_in,
    input  wire logic                     dq_oe_in
);
    localparam int DW = LANES*`LANE_W;
    typedef struct packed {
        sram_port_pkg::op_t op;
        logic               off;
        logic [DW-1:0]      data;
    } stage_t;
    stage_t        cur_r = '0;
    stage_t        s1_r  = '0;
    stage_t        s2_r  = '0;
    stage_t        s3_r  = '0;
    // {op, oe, data} of each data phase, popped by the bench
    logic [DW+2:0] rec_q[$];

    initial begin
        clock_gate_n_out     = 1'b0;
        addr_out             = '0;
        ctl_out              = sram_port_pkg::ctl_pins_t'(5'h15);
        lane_write_sel_n_out = '1;
        dq_out               = '0;
        out_en_n_out         = 1'b0;
        sleep_req_out        = 1'b0;
        burst_mode_out       = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // gated edges freeze pipeline
    always @(posedge sys_clk_in) begin
        if (!clock_gate_n_out) begin
            s1_r <= cur_r;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // write data lags address; released line keeps toggling
            dq_out <= (s1_r.op == sram_port_pkg::OP_WRITE) ? s1_r.data
                                                           : ~dq_out;
            out_en_n_out <= s2_r.off;
            if (s3_r.op != sram_port_pkg::OP_NOP)
                rec_q.push_back({s3_r.op, dq_oe_in, dq_in});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // select and lane pins
    task automatic put(input sram_port_pkg::op_t op, input logic adv,
        input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln,
        input logic [DW-1:0] d, input logic off, input logic [2:0] sel,
        input int hold);
        sram_port_pkg::op_t o;
        o = (sel == 3'b010 && !sleep_req_out) ? op : sram_port_pkg::OP_NOP;
        @(posedge sys_clk_in);
        addr_out             <= a;
        ctl_out              <= {op != sram_port_pkg::OP_WRITE, adv, sel};
        lane_write_sel_n_out <= ln;
        clock_gate_n_out     <= (hold > 0);
        cur_r                <= '{adv ? cur_r.op : o, off, d};
        if (hold > 0) begin
            repeat (hold) @(posedge sys_clk_in);
            clock_gate_n_out <= 1'b0;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) put(sram_port_pkg::OP_NOP, 1'b0, '0, '1, '0, 1'b0,
                       3'b110, 0);
    endtask

    task automatic pins(input logic slp, input logic strap);
        @(posedge sys_clk_in);
        sleep_req_out  <= slp;
        burst_mode_out <= strap;
    endtask
endmodule

// [test/testbench.sv]
// self-checking bench for the burst port against a controller model
// assumes the x36 build and the two-edge data latency of the port
`timescale 1ns/1ps
`include "sram_port_consts.svh"

module testbench;
    localparam int AW = `X36_ADDR_W;
    localparam int LN = `X36_LANES;
    localparam int DW = LN*`LANE_W;
    logic                     sys_clk_in = 1'b0;
    logic                     rst_n_in   = 1'b0;
    logic                     gate_n;
    logic [AW-1:0]            addr;
    sram_port_pkg::ctl_pins_t ctl;
    logic [LN-1:0]            lanes_n;
    logic [DW-1:0]            dq_w;
    logic [DW-1:0]            dq_r;
    logic                     oe_n;
    logic                     sleep;
    logic                     strap;
    logic                     dq_oe;
    int                       failures    = 0;
    int                       check_count = 0;
    int                       oe_hits     = 0;
    logic [DW-1:0]            mem[logic [AW-1:0]];
    logic [DW+2:0]            exp_q[$];

    always #12.5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) if (dq_oe === 1'b1) oe_hits++;

    sram_burst_port #(.ADDR_W(AW), .LANES(LN)) i_dut (
        .sys_clk_in          (sys_clk_in),
        .rst_n_in            (rst_n_in),
        .clock_gate_n_in     (gate_n),
        .addr_in             (addr),
        .ctl_in              (ctl),
        .lane_write_sel_n_in (lanes_n),
        .dq_in               (dq_w),
        .out_en_n_in         (oe_n),
        .sleep_req_in        (sleep),
        .burst_mode_in       (strap),
        .dq_out              (dq_r),
        .dq_oe_out           (dq_oe)
    );

    sram_ctrl_model #(.ADDR_W(AW), .LANES(LN)) i_ctrl (
        .sys_clk_in           (sys_clk_in),
        .clock_gate_n_out     (gate_n),
        .addr_out             (addr),
        .ctl_out              (ctl),
        .lane_write_sel_n_out (lanes_n),
        .dq_out               (dq_w),
        .out_en_n_out         (oe_n),
        .sleep_req_out        (sleep),
        .burst_mode_out       (strap),
        .dq_in                (dq_r),
        .dq_oe_in             (dq_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [DW:0] e,
        input logic [DW:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one transfer with its expectation worked out in program order
    task automatic xfer(input sram_port_pkg::op_t op, input logic adv,
        input logic [AW-1:0] a, input logic [LN-1:0] ln,
        input logic [DW-1:0] d, input logic off, input int hold);
        logic [DW-1:0] v;
        v = mem.exists(a) ? mem[a] : '0;
        for (int l = 0; l < LN; l++)
            if (op == sram_port_pkg::OP_WRITE && !ln[l])
                v[l*`LANE_W +: `LANE_W] = d[l*`LANE_W +: `LANE_W];
        if (op == sram_port_pkg::OP_WRITE) mem[a] = v;
        exp_q.push_back({op, op == sram_port_pkg::OP_READ && !off, v});
        i_ctrl.put(op, adv, a, ln, d, off, 3'b010, hold);
    endtask

    task automatic flush();
        logic [DW+2:0] e;
        logic [DW+2:0] g;
        i_ctrl.idle(5);
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            g = (i_ctrl.rec_q.size() > 0) ? i_ctrl.rec_q.pop_front() : '1;
            check("dq_oe_out", {1'b0, e[DW]}, {1'b0, g[DW]});
            if (e[DW]) check("dq_out", e[DW:0], g[DW:0]);
        end
        check("extra phases", '0, (DW+1)'(i_ctrl.rec_q.size()));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset(input logic il);
        rst_n_in <= 1'b0;
        i_ctrl.pins(1'b0, il);
        repeat (20) @(posedge sys_clk_in);
        check("reset oe", '0, {DW'(0), dq_oe});
        check("reset dq", '0, {1'b0, dq_r});
        rst_n_in <= 1'b1;
        i_ctrl.idle(3);
    endtask

    task automatic t_mix();
        xfer(sram_port_pkg::OP_WRITE, 0, 19'h10, 4'h0, 36'h1_2345_6789, 0, 0);
        xfer(sram_port_pkg::OP_READ, 0, 19'h10, 4'hf, '0, 0, 0);
        xfer(sram_port_pkg::OP_WRITE, 0, 19'h11, 4'h0, 36'h0_aaaa_5555, 0, 0);
        xfer(sram_port_pkg::OP_WRITE, 0, 19'h11, 4'ha, '1, 0, 0);
        xfer(sram_port_pkg::OP_READ, 0, 19'h11, 4'hf, '0, 0, 0);
        xfer(sram_port_pkg::OP_READ, 0, 19'h10, 4'hf, '0, 0, 0);
        flush();
    endtask

    task automatic t_gate();
        xfer(sram_port_pkg::OP_WRITE, 0, 19'h11, 4'h5, 36'h3_0f0f_0f0f, 0, 2);
        xfer(sram_port_pkg::OP_READ, 0, 19'h11, 4'hf, '0, 0, 3);
        xfer(sram_port_pkg::OP_READ, 0, 19'h10, 4'hf, '0, 0, 1);
        flush();
    endtask

    task automatic t_out_en();
        xfer(sram_port_pkg::OP_READ, 0, 19'h10, 4'hf, '0, 1, 0);
        xfer(sram_port_pkg::OP_READ, 0, 19'h11, 4'hf, '0, 0, 0);
        flush();
    endtask

    // refused loads must never open a data phase
    task automatic t_refused();
        int h;
        h = oe_hits;
        for (int s = 0; s < 8; s++)
            if (s != 2) i_ctrl.put(sram_port_pkg::OP_READ, 0, 19'h10, '1,
                                   '0, 0, s[2:0], 0);
        i_ctrl.pins(1'b1, strap);
        i_ctrl.idle(3);
        i_ctrl.put(sram_port_pkg::OP_READ, 0, 19'h10, '1, '0, 0, 3'b010, 0);
        i_ctrl.idle(5);
        check("refused oe", (DW+1)'(h), (DW+1)'(oe_hits));
        flush();
        i_ctrl.pins(1'b0, strap);
        i_ctrl.idle(3);
    endtask

    task automatic t_burst(input logic il);
        logic [AW-1:0] a;
        for (int c = 0; c < 4; c++)
            xfer(sram_port_pkg::OP_WRITE, c > 0, {17'h10, 2'(c)}, 4'h0,
                 {32'h9abc_0000 + 32'(c), 4'h5}, 0, 0);
        for (int c = 0; c < 4; c++) begin
            a = {17'h10, il ? 2'(1 ^ c) : 2'(1 + c)};
            xfer(sram_port_pkg::OP_READ, c > 0, a, 4'hf, '0, 0, 0);
        end
        flush();
    endtask

    initial begin
        #(3000*25);
        failures++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        t_reset(1'b0);
        t_mix();
        t_gate();
        t_out_en();
        t_refused();
        t_burst(1'b0);
        t_reset(1'b1);
        t_burst(1'b1);
        conclude();
    end
endmodule
